// file: inc/qwa_pkg.sv
// Constants and carrier types for the quad wiper block
package qwa_pkg;
   // ----
   // Sizes
   // ----
   localparam int unsigned CHANNELS   = 4;
   localparam int unsigned CODE_W     = 8;
   localparam int unsigned CTRL_W     = 4;
   localparam int unsigned ADDR_W     = 4;
   localparam int unsigned CH_W       = 2;
   localparam int unsigned TAP_W      = 9;

   // ----
   // Address field positions
   // ----
   localparam int unsigned ADDR_BCAST = 3;
   localparam int unsigned ADDR_SEG   = 2;
   localparam int unsigned ADDR_CHHI  = 1;
   localparam int unsigned ADDR_CHLO  = 0;

   // ----
   // Control register field positions and reset value
   // ----
   localparam int unsigned CTL_WP     = 0;
   localparam int unsigned CTL_NVPE   = 1;
   localparam int unsigned CTL_GAIN   = 2;
   localparam int unsigned CTL_BURST  = 3;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h3;

   // ----
   // Code range limits per resolution
   // ----
   localparam logic [CODE_W-1:0] MAX_CODE_128 = 8'h7f;
   localparam logic [CODE_W-1:0] MAX_CODE_256 = 8'hff;
   localparam logic [CODE_W-1:0] CODE_ZERO    = 8'h00;

   // ----
   // Commands presented by the serial front end
   // ----
   typedef enum logic [3:0] {
      QWA_CMD_NOP       = 4'h0,
      QWA_CMD_WR_INPUT  = 4'h1,
      QWA_CMD_WR_WIPER  = 4'h2,
      QWA_CMD_COPY_IN   = 4'h3,
      QWA_CMD_NV_STORE  = 4'h4,
      QWA_CMD_NV_RECALL = 4'h5,
      QWA_CMD_NV_WRITE  = 4'h6,
      QWA_CMD_SCALE     = 4'h7,
      QWA_CMD_SHUTDOWN  = 4'h8,
      QWA_CMD_WR_CTRL   = 4'h9,
      QWA_CMD_SW_RESET  = 4'ha
   } qwa_cmd_e;

   // Request carried from the serial front end
   typedef struct packed {
      qwa_cmd_e            cmd;
      logic [ADDR_W-1:0]   addr;
      logic [CODE_W-1:0]   data;
   } qwa_req_s;

   // Per-channel tap outputs
   typedef struct packed {
      logic [TAP_W-1:0]    wb_tap;
      logic [TAP_W-1:0]    aw_tap;
   } qwa_tap_s;

   // Preset sequencer states
   typedef enum logic [1:0] {
      QWA_ST_PRESET = 2'b00,
      QWA_ST_RUN    = 2'b01
   } qwa_state_e;
endpackage : qwa_pkg

// file: rtl/qwa_addr_dec.sv
// Address decoder: command address bits to per-channel register selects
`timescale 1ns/10ps
module qwa_addr_dec #(
   parameter int unsigned CHANNELS = qwa_pkg::CHANNELS
) (
   input  wire logic [qwa_pkg::ADDR_W-1:0] addr,
   input  wire logic                       gain_mode_select,
   output logic      [CHANNELS-1:0]        sel_wb,
   output logic      [CHANNELS-1:0]        sel_aw,
   output logic                            nv_addr_ok
);
   logic broadcast_addr_bit;
   logic segment_select_addr_bit;
   logic [qwa_pkg::CH_W-1:0] chan;

   assign broadcast_addr_bit      = addr[qwa_pkg::ADDR_BCAST];
   assign segment_select_addr_bit = addr[qwa_pkg::ADDR_SEG];
   assign chan = {addr[qwa_pkg::ADDR_CHHI], addr[qwa_pkg::ADDR_CHLO]};

   // ----
   // Per-channel selects
   // ----
   for (genvar i = 0; i < CHANNELS; i++) begin : g_sel
      always_comb begin
         if (broadcast_addr_bit) begin
            sel_wb[i] = 1'b1;                                  // RQ12
            sel_aw[i] = gain_mode_select;                      // RQ12
         end else if (chan == qwa_pkg::CH_W'(i)) begin
            // Segment bit picks the A-side code only in gain mode
            sel_wb[i] = !segment_select_addr_bit;              // RQ1 RQ2
            sel_aw[i] = segment_select_addr_bit && gain_mode_select; // RQ2
         end else begin
            sel_wb[i] = 1'b0;
            sel_aw[i] = 1'b0;
         end
      end
   end

   // Store and recall reach only single wiper-to-B registers
   assign nv_addr_ok = !broadcast_addr_bit && !segment_select_addr_bit; // RQ12
endmodule : qwa_addr_dec

// file: rtl/qwa_tap_map.sv
// Tap mapping: wiper codes to wiper-to-B and A-to-wiper tap positions
`timescale 1ns/10ps
module qwa_tap_map #(
   parameter int unsigned CODE_BITS = 8
) (
   input  wire logic [qwa_pkg::CODE_W-1:0] wb_code,
   input  wire logic [qwa_pkg::CODE_W-1:0] aw_code,
   input  wire logic                       gain_mode_select,
   input  wire logic                       top_scale,
   input  wire logic                       bottom_scale,
   output qwa_pkg::qwa_tap_s               tap
);
   localparam logic [qwa_pkg::TAP_W-1:0] FULL = qwa_pkg::TAP_W'(1 << CODE_BITS);
   localparam logic [qwa_pkg::CODE_W-1:0] MASK = qwa_pkg::CODE_W'((1 << CODE_BITS) - 1);

   logic [qwa_pkg::TAP_W-1:0] wb_lin;
   logic [qwa_pkg::TAP_W-1:0] aw_lin;

   // Codes above the part's range are masked to its width
   assign wb_lin = {1'b0, wb_code & MASK};                     // RQ7 RQ8
   assign aw_lin = {1'b0, aw_code & MASK};                     // RQ7

   // ----
   // Segment selection with extra scale positions
   // ----
   always_comb begin
      if (top_scale) begin
         tap.wb_tap = FULL;
         tap.aw_tap = FULL - 9'h001;                           // RQ11
      end else if (bottom_scale) begin
         tap.wb_tap = '0;
         tap.aw_tap = FULL;
      end else begin
         tap.wb_tap = wb_lin;                                  // RQ8
         if (gain_mode_select) begin
            tap.aw_tap = aw_lin;                               // RQ10
         end else begin
            tap.aw_tap = FULL - wb_lin;                        // RQ9
         end
      end
   end
endmodule : qwa_tap_map

// file: rtl/qwa_wiper_ctrl.sv
// Quad wiper address and control: code registers, control register, preset
`timescale 1ns/10ps
// Behaviour
// [RQ1] Potentiometer mode: low bits pick channel wiper
// [RQ2] Gain mode: segment bit picks B or A code
// [RQ3] Write protect clear freezes wipers at stored; code reloads only wiper-to-B, gain A-side and scale positions hold
// [RQ4] Program enable clear refuses nonvolatile writes
// [RQ5] Mode bit: potentiometer default, gain optional
// [RQ6] Burst enable survives stop and repeated start
// [RQ7] Seven or eight bit code picks tap
// [RQ8] Wiper-to-B tap rises linearly with code
// [RQ9] Potentiometer A-side is code complement
// [RQ10] Gain mode A-side follows own register
// [RQ11] Extra top, bottom scale; top one shorter
// [RQ12] Broadcast writes all; invalid for store/recall
// [RQ13] Preset loads wipers from stored values
// [RQ14] Shutdown data one enters, zero exits
module qwa_wiper_ctrl #(
   parameter int unsigned CHANNELS  = qwa_pkg::CHANNELS,
   parameter int unsigned CODE_BITS = 8
) (
   input  wire logic                       clk_sys,
   input  wire logic                       nrst,
   input  wire logic                       clk_en,
   input  wire logic                       req_valid,
   input  qwa_pkg::qwa_req_s               req,
   input  wire logic                       bus_stop,
   output logic                            req_refused,
   output logic      [qwa_pkg::CTRL_W-1:0] device_control,
   output logic                            burst_active,
   output logic                            shutdown,
   output logic                            preset_busy,
   output logic      [qwa_pkg::CODE_W-1:0] nv_code   [CHANNELS],
   output qwa_pkg::qwa_tap_s               tap       [CHANNELS]
);
   // ----
   // State
   // ----
   logic [qwa_pkg::CODE_W-1:0] wb_q [CHANNELS];
   logic [qwa_pkg::CODE_W-1:0] wb_d [CHANNELS];
   logic [qwa_pkg::CODE_W-1:0] aw_q [CHANNELS];
   logic [qwa_pkg::CODE_W-1:0] aw_d [CHANNELS];
   logic [qwa_pkg::CODE_W-1:0] in_q [CHANNELS];
   logic [qwa_pkg::CODE_W-1:0] in_d [CHANNELS];
   logic [qwa_pkg::CODE_W-1:0] nv_q [CHANNELS];
   logic [qwa_pkg::CODE_W-1:0] nv_d [CHANNELS];
   logic [CHANNELS-1:0]        top_q;
   logic [CHANNELS-1:0]        top_d;
   logic [CHANNELS-1:0]        bot_q;
   logic [CHANNELS-1:0]        bot_d;
   logic [qwa_pkg::CTRL_W-1:0] ctrl_q;
   logic [qwa_pkg::CTRL_W-1:0] ctrl_d;
   logic                       burst_q;
   logic                       burst_d;
   logic                       shdn_q;
   logic                       shdn_d;
   logic                       refused_q;
   logic                       refused_d;
   qwa_pkg::qwa_state_e        state_q;
   qwa_pkg::qwa_state_e        state_d;

   // Decoder outputs and field views
   logic [CHANNELS-1:0]        sel_wb;
   logic [CHANNELS-1:0]        sel_aw;
   logic                       nv_addr_ok;
   logic [qwa_pkg::CH_W-1:0]   chan;
   logic                       wiper_write_protect;
   logic                       nv_program_enable;
   logic                       gain_mode_select;
   logic                       i2c_burst_enable;
   logic                       take;

   // ----
   // Field views
   // ----
   assign wiper_write_protect = ctrl_q[qwa_pkg::CTL_WP];
   assign nv_program_enable   = ctrl_q[qwa_pkg::CTL_NVPE];
   assign gain_mode_select    = ctrl_q[qwa_pkg::CTL_GAIN];   // RQ5
   assign i2c_burst_enable    = ctrl_q[qwa_pkg::CTL_BURST];
   // Channel for store, write, recall
   assign chan = {req.addr[qwa_pkg::ADDR_CHHI], req.addr[qwa_pkg::ADDR_CHLO]};
   // Words during preset are dropped
   assign take = req_valid && (state_q == qwa_pkg::QWA_ST_RUN);

   // ----
   // Address decode
   // ----
   // Protect and program-enable gating stays here, not in decoder
   qwa_addr_dec #(
      .CHANNELS         (CHANNELS)
   ) i_qwa_addr_dec (
      .addr             (req.addr),
      .gain_mode_select (gain_mode_select),
      .sel_wb           (sel_wb),
      .sel_aw           (sel_aw),
      .nv_addr_ok       (nv_addr_ok)
   );

   // ----
   // Control, burst, shutdown, preset and refusal next state
   // ----
   always_comb begin
      ctrl_d    = ctrl_q;
      burst_d   = burst_q;
      shdn_d    = shdn_q;
      state_d   = state_q;
      refused_d = 1'b0;
      unique case (state_q)
         qwa_pkg::QWA_ST_PRESET: begin
            state_d = qwa_pkg::QWA_ST_RUN;                     // RQ13
         end
         qwa_pkg::QWA_ST_RUN: begin
            // Stop or repeated start ends a burst unless burst is enabled
            // Enable clear leaves burst set till stop
            if (bus_stop && !i2c_burst_enable) begin
               burst_d = 1'b0;                                 // RQ6
            end else if (i2c_burst_enable) begin
               burst_d = 1'b1;                                 // RQ6
            end
            if (take) begin
               unique case (req.cmd)
                  qwa_pkg::QWA_CMD_WR_CTRL: begin
                     ctrl_d = req.data[qwa_pkg::CTRL_W-1:0];
                  end
                  qwa_pkg::QWA_CMD_SHUTDOWN: begin
                     shdn_d = req.data[0];                     // RQ14
                  end
                  qwa_pkg::QWA_CMD_SW_RESET: begin
                     state_d = qwa_pkg::QWA_ST_PRESET;
                  end
                  qwa_pkg::QWA_CMD_WR_WIPER,
                  qwa_pkg::QWA_CMD_COPY_IN,
                  qwa_pkg::QWA_CMD_SCALE: begin
                     refused_d = !wiper_write_protect;         // RQ3
                  end
                  qwa_pkg::QWA_CMD_NV_STORE,
                  qwa_pkg::QWA_CMD_NV_WRITE: begin
                     refused_d = !nv_program_enable || !nv_addr_ok; // RQ4 RQ12
                  end
                  qwa_pkg::QWA_CMD_NV_RECALL: begin
                     refused_d = !nv_addr_ok;                  // RQ12
                  end
                  default: begin
                     refused_d = 1'b0;
                  end
               endcase
            end
         end
         default: begin
            state_d = qwa_pkg::QWA_ST_PRESET;
         end
      endcase
   end

   // ----
   // Per-channel code registers
   // ----
   // One register set per channel
   for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
      logic own;
      assign own = (chan == qwa_pkg::CH_W'(i));

      always_comb begin
         wb_d[i]  = wb_q[i];
         aw_d[i]  = aw_q[i];
         in_d[i]  = in_q[i];
         nv_d[i]  = nv_q[i];
         top_d[i] = top_q[i];
         bot_d[i] = bot_q[i];
         if (state_q == qwa_pkg::QWA_ST_PRESET) begin
            // Preset restores stored codes and clears the scale positions
            wb_d[i]  = nv_q[i];                                // RQ13
            aw_d[i]  = nv_q[i];                                // RQ13
            top_d[i] = 1'b0;
            bot_d[i] = 1'b0;
         end else if (!wiper_write_protect) begin
            // Reloaded each cycle while clear
            wb_d[i] = nv_q[i];                                 // RQ3
         end
         if (take) begin
            unique case (req.cmd)
               qwa_pkg::QWA_CMD_WR_INPUT: begin
                  if (sel_wb[i] || sel_aw[i]) begin
                     in_d[i] = req.data;                       // RQ12
                  end
               end
               qwa_pkg::QWA_CMD_WR_WIPER,
               qwa_pkg::QWA_CMD_COPY_IN: begin
                  if (wiper_write_protect) begin               // RQ3
                     if (sel_wb[i]) begin
                        wb_d[i] = (req.cmd == qwa_pkg::QWA_CMD_COPY_IN) ? in_q[i]
                                                                        : req.data;
                     end
                     if (sel_aw[i]) begin
                        aw_d[i] = (req.cmd == qwa_pkg::QWA_CMD_COPY_IN) ? in_q[i]
                                                                        : req.data; // RQ10
                     end
                  end
               end
               qwa_pkg::QWA_CMD_SCALE: begin
                  if (wiper_write_protect && (sel_wb[i] || sel_aw[i])) begin
                     // Data bit 7 picks top, bit 0 enters or exits
                     if (req.data[qwa_pkg::CODE_W-1]) begin
                        top_d[i] = req.data[0];                // RQ11
                     end else begin
                        bot_d[i] = req.data[0];                // RQ11
                     end
                  end
               end
               qwa_pkg::QWA_CMD_NV_STORE: begin
                  if (nv_program_enable && nv_addr_ok && own) begin
                     nv_d[i] = wb_q[i];                        // RQ4
                  end
               end
               qwa_pkg::QWA_CMD_NV_WRITE: begin
                  if (nv_program_enable && nv_addr_ok && own) begin
                     nv_d[i] = req.data;                       // RQ4
                  end
               end
               qwa_pkg::QWA_CMD_NV_RECALL: begin
                  if (nv_addr_ok && own) begin
                     wb_d[i] = nv_q[i];                        // RQ12
                  end
               end
               default: begin
                  // Other commands leave codes alone
               end
            endcase
         end
      end

      // ----
      // Per-channel flip-flops
      // ----
      // Reset clears it, as blank storage would
      always_ff @(posedge clk_sys) begin
         if (!nrst) begin
            nv_q[i] <= qwa_pkg::CODE_ZERO;
         end else if (clk_en) begin
            nv_q[i] <= nv_d[i];
         end
      end

      always_ff @(posedge clk_sys) begin
         if (!nrst) begin
            wb_q[i]  <= qwa_pkg::CODE_ZERO;
            aw_q[i]  <= qwa_pkg::CODE_ZERO;
            in_q[i]  <= qwa_pkg::CODE_ZERO;
            top_q[i] <= 1'b0;
            bot_q[i] <= 1'b0;
         end else if (clk_en) begin
            wb_q[i]  <= wb_d[i];
            aw_q[i]  <= aw_d[i];
            in_q[i]  <= in_d[i];
            top_q[i] <= top_d[i];
            bot_q[i] <= bot_d[i];
         end
      end

      // ----
      // Tap decode
      // ----
      qwa_tap_map #(
         .CODE_BITS        (CODE_BITS)
      ) i_qwa_tap_map (
         .wb_code          (wb_q[i]),
         .aw_code          (aw_q[i]),
         .gain_mode_select (gain_mode_select),
         .top_scale        (top_q[i]),
         .bottom_scale     (bot_q[i]),
         .tap              (tap[i])                            // RQ7
      );

      assign nv_code[i] = nv_q[i];
   end

   // ----
   // Control state registers
   // ----
   // Comes up write and program enabled
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ctrl_q    <= qwa_pkg::CTRL_RESET;                     // RQ3 RQ4 RQ5 RQ6
         burst_q   <= 1'b0;
         shdn_q    <= 1'b0;
         refused_q <= 1'b0;
         state_q   <= qwa_pkg::QWA_ST_PRESET;                  // RQ13
      end else if (clk_en) begin
         ctrl_q    <= ctrl_d;
         burst_q   <= burst_d;
         shdn_q    <= shdn_d;
         refused_q <= refused_d;
         state_q   <= state_d;
      end
   end

   // Outputs straight from flip-flops; preset_busy decoded from state_q
   assign device_control = ctrl_q;
   assign burst_active   = burst_q;
   assign shutdown       = shdn_q;
   assign req_refused    = refused_q;
   assign preset_busy    = (state_q == qwa_pkg::QWA_ST_PRESET);
endmodule : qwa_wiper_ctrl

// file: tb/qwa_host_model.sv
// Host model presenting command words to the wiper block
`timescale 1ns/10ps
module qwa_host_model (
   input  wire logic         clk_sys,
   output logic              req_valid,
   output qwa_pkg::qwa_req_s req,
   output logic              bus_stop
);
   // Idle until the bench asks for traffic
   initial begin
      req_valid = 1'b0;
      req = '0;
      bus_stop = 1'b0;
   end
   // One word, held over exactly the edge that takes it
   task automatic send(input qwa_pkg::qwa_cmd_e c, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      req_valid = 1'b1;
      req = '{c, a, d};
      @(posedge clk_sys);
      #1;
      req_valid = 1'b0;
      req = qwa_pkg::qwa_req_s'(~req); // Released word shows junk, not the last value
   endtask : send
   // Stop or repeated start seen on the serial side
   task automatic stop();
      @(posedge clk_sys);
      #1;
      bus_stop = 1'b1;
      @(posedge clk_sys);
      #1;
      bus_stop = 1'b0;
   endtask : stop
endmodule : qwa_host_model

// file: tb/qwa_wiper_ctrl_asserts.sv
// Port-level checker for the quad wiper control block
`timescale 1ns/10ps
module qwa_wiper_ctrl_asserts #(
   parameter int unsigned CHANNELS  = qwa_pkg::CHANNELS,
   parameter int unsigned CODE_BITS = 8
) (
   input  wire logic                       clk_sys,
   input  wire logic                       nrst,
   input  wire logic                       clk_en,
   input  wire logic                       req_valid,
   input  qwa_pkg::qwa_req_s               req,
   input  wire logic                       bus_stop,
   input  wire logic                       req_refused,
   input  wire logic [qwa_pkg::CTRL_W-1:0] device_control,
   input  wire logic                       burst_active,
   input  wire logic                       shutdown,
   input  wire logic                       preset_busy,
   input  wire logic [qwa_pkg::CODE_W-1:0] nv_code [CHANNELS],
   input  qwa_pkg::qwa_tap_s               tap     [CHANNELS]
);
   localparam logic [8:0] FULL = 9'(1 << CODE_BITS);
   logic       take;
   logic       pend_q;
   logic       seg_q;
   logic [1:0] ch_q;
   logic [7:0] dat_q;
   // Request accepted at this edge
   assign take = clk_en & req_valid & !preset_busy;
   // Accepted wiper write, its tap checked one edge later
   always_ff @(posedge clk_sys) begin
      pend_q <= nrst & take & (req.cmd == qwa_pkg::QWA_CMD_WR_WIPER) & device_control[0]
                & !req.addr[3] & (device_control[2] | !req.addr[2]);
      seg_q  <= req.addr[2];
      ch_q   <= req.addr[1:0];
      dat_q  <= req.data;
   end
   // ----
   // Relations
   // ----
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   wiper_load_a: assert property (
      pend_q && !seg_q |-> tap[ch_q].wb_tap == ({1'b0, dat_q} & (FULL - 9'h1)))
      else $error("wiper code not loaded");
   seg_load_a: assert property (
      pend_q && seg_q |-> tap[ch_q].aw_tap == {1'b0, dat_q})
      else $error("a-side code not loaded");
   pot_comp_a: assert property (
      !device_control[2] && tap[0].wb_tap != 9'h0 && tap[0].wb_tap < FULL
      |-> tap[0].aw_tap == FULL - tap[0].wb_tap) else $error("a-side not complement");
   top_scale_a: assert property (
      tap[1].wb_tap == FULL |-> tap[1].aw_tap == FULL - 9'h1) else $error("top scale a-side");
   protect_a: assert property (
      take && req.cmd == qwa_pkg::QWA_CMD_WR_WIPER && !device_control[0] |=> req_refused)
      else $error("protected write not refused");
   nv_lock_a: assert property (
      take && req.cmd == qwa_pkg::QWA_CMD_NV_STORE && !device_control[1] |=> req_refused)
      else $error("store not refused");
   nv_addr_a: assert property (
      take && (req.cmd == qwa_pkg::QWA_CMD_NV_STORE || req.cmd == qwa_pkg::QWA_CMD_NV_RECALL)
      && (req.addr[3] || req.addr[2]) |=> req_refused) else $error("bad store address taken");
   ctrl_write_a: assert property (
      take && req.cmd == qwa_pkg::QWA_CMD_WR_CTRL |=> device_control == $past(req.data[3:0]))
      else $error("control write lost");
   shut_a: assert property (
      take && req.cmd == qwa_pkg::QWA_CMD_SHUTDOWN |=> shutdown == $past(req.data[0]))
      else $error("shutdown level wrong");
   burst_hold_a: assert property (
      clk_en && !take && device_control[3] && burst_active && bus_stop |=> burst_active)
      else $error("burst cancelled by stop");
   preset_a: assert property (
      clk_en && preset_busy |=> !preset_busy) else $error("preset longer than one cycle");
   gain_cov: cover property (pend_q && seg_q);
   refuse_cov: cover property (req_refused);
   top_cov: cover property (tap[1].wb_tap == FULL);
endmodule : qwa_wiper_ctrl_asserts
bind qwa_wiper_ctrl qwa_wiper_ctrl_asserts #(.CHANNELS(CHANNELS), .CODE_BITS(CODE_BITS))
   i_qwa_wiper_ctrl_asserts (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
   .req_valid(req_valid), .req(req), .bus_stop(bus_stop), .req_refused(req_refused),
   .device_control(device_control), .burst_active(burst_active), .shutdown(shutdown),
   .preset_busy(preset_busy), .nv_code(nv_code), .tap(tap));

// file: tb/qwa_wiper_ctrl_bench.sv
// Self-checking bench for the quad wiper control block
`timescale 1ns/10ps
module qwa_wiper_ctrl_bench;
   typedef struct packed {
      logic [3:0][17:0] taps;
      logic [3:0]       ctl;
      logic             shut;
      logic [1:0]       rf;
      logic             chk_tap;
   } qwa_note_s;
   logic              clk_sys = 1'b0;
   logic              nrst = 1'b0;
   logic              clk_en = 1'b1;
   logic              req_valid;
   qwa_pkg::qwa_req_s req;
   logic              bus_stop;
   logic              req_refused;
   logic              burst_active;
   logic              shutdown;
   logic              preset_busy;
   logic [3:0]        device_control;
   logic [7:0]        nv_code [4];
   qwa_pkg::qwa_tap_s tap     [4];
   qwa_note_s         notes[$];
   logic [8:0]        ewb [4];
   logic [8:0]        eaw [4];
   logic [3:0]        ectl = 4'h3;
   logic              eshut = 1'b0;
   logic [31:0]       seed = 32'h7567;
   int                fails = 0;
   int                check_count = 0;
   int                cyc = 0;

   always #2.5 clk_sys = ~clk_sys;

   qwa_wiper_ctrl i_qwa_wiper_ctrl (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
      .req_valid(req_valid), .req(req), .bus_stop(bus_stop), .req_refused(req_refused),
      .device_control(device_control), .burst_active(burst_active), .shutdown(shutdown),
      .preset_busy(preset_busy), .nv_code(nv_code), .tap(tap));
   qwa_host_model i_qwa_host_model (.clk_sys(clk_sys), .req_valid(req_valid), .req(req),
      .bus_stop(bus_stop));

   // ----
   // Helpers
   // ----
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   // Pot mode keeps the a-side as complement, so model it here
   task automatic setw(input int ch, input logic [7:0] d);
      ewb[ch] = {1'b0, d};
      eaw[ch] = 9'h100 - {1'b0, d};
   endtask : setw
   // Note the expected state, then send; rf 2 means refusal not judged
   task automatic op(input qwa_pkg::qwa_cmd_e c, input logic [3:0] a, input logic [7:0] d,
                     input logic [1:0] rf, input logic ct);
      qwa_note_s n;
      for (int i = 0; i < 4; i++) n.taps[i] = {ewb[i], eaw[i]};
      n.ctl = ectl;
      n.shut = eshut;
      n.rf = rf;
      n.chk_tap = ct;
      notes.push_back(n);
      i_qwa_host_model.send(c, a, d);
   endtask : op

   // Watcher: one note per taken word, checked once settled
   always @(posedge clk_sys) begin
      qwa_note_s n;
      if (nrst && clk_en && req_valid && !preset_busy) begin
         #2;
         n = notes.pop_front();
         if (n.chk_tap) for (int i = 0; i < 4; i++) chk(72'(tap[i]), 72'(n.taps[i]));
         chk(72'({device_control, shutdown}), 72'({n.ctl, n.shut}));
         if (!n.rf[1]) chk(72'(req_refused), 72'(n.rf[0]));
      end
   end
   // Hang guard, well above the run's length
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         tally_and_finish();
      end
   end

   // Main sequence
   initial begin
      logic [7:0] d;
      logic [7:0] nvs;
      for (int i = 0; i < 4; i++) setw(i, 8'h00);
      repeat (10) @(posedge clk_sys);
      #1 nrst = 1'b1;
      chk(72'(preset_busy), 72'(1'b1));
      repeat (2) @(posedge clk_sys);
      op(qwa_pkg::QWA_CMD_NOP, 4'h0, 8'h00, 2'd2, 1'b1);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'(xs());
         setw(i % 4, d);
         op(qwa_pkg::QWA_CMD_WR_WIPER, 4'(i % 4), d, 2'd0, 1'b1);
      end
      op(qwa_pkg::QWA_CMD_WR_WIPER, 4'h5, 8'h33, 2'd2, 1'b1);
      d = 8'(xs());
      for (int i = 0; i < 4; i++) setw(i, d);
      op(qwa_pkg::QWA_CMD_WR_WIPER, 4'h8, d, 2'd0, 1'b1);
      $display("potentiometer test done");
      ectl = 4'h7;
      op(qwa_pkg::QWA_CMD_WR_CTRL, 4'h0, 8'h07, 2'd0, 1'b0);
      d = 8'(xs());
      for (int i = 0; i < 4; i++) {ewb[i], eaw[i]} = {1'b0, d, 1'b0, d};
      op(qwa_pkg::QWA_CMD_WR_WIPER, 4'h8, d, 2'd0, 1'b1);
      eaw[2] = 9'h05;
      op(qwa_pkg::QWA_CMD_WR_WIPER, 4'h6, 8'h05, 2'd0, 1'b1);
      ewb[2] = 9'hc3;
      op(qwa_pkg::QWA_CMD_WR_WIPER, 4'h2, 8'hc3, 2'd0, 1'b1);
      ectl = 4'h3;
      for (int i = 0; i < 4; i++) setw(i, ewb[i][7:0]);
      op(qwa_pkg::QWA_CMD_WR_CTRL, 4'h0, 8'h03, 2'd0, 1'b1);
      $display("gain test done");
      nvs = ewb[1][7:0];
      op(qwa_pkg::QWA_CMD_NV_STORE, 4'h1, 8'h00, 2'd0, 1'b1);
      chk(72'(nv_code[1]), 72'(nvs));
      op(qwa_pkg::QWA_CMD_NV_STORE, 4'h9, 8'h00, 2'd1, 1'b1);
      op(qwa_pkg::QWA_CMD_NV_RECALL, 4'h4, 8'h00, 2'd1, 1'b1);
      ectl = 4'h2;
      op(qwa_pkg::QWA_CMD_WR_CTRL, 4'h0, 8'h02, 2'd0, 1'b1);
      for (int i = 0; i < 4; i++) setw(i, (i == 1) ? nvs : 8'h00);
      op(qwa_pkg::QWA_CMD_WR_WIPER, 4'h1, 8'h12, 2'd1, 1'b1);
      ectl = 4'h1;
      op(qwa_pkg::QWA_CMD_WR_CTRL, 4'h0, 8'h01, 2'd0, 1'b1);
      op(qwa_pkg::QWA_CMD_NV_STORE, 4'h0, 8'h00, 2'd1, 1'b1);
      $display("protect test done");
      ectl = 4'hb;
      op(qwa_pkg::QWA_CMD_WR_CTRL, 4'h0, 8'h0b, 2'd0, 1'b1);
      @(posedge clk_sys) #1 chk(72'(burst_active), 72'(1'b1));
      i_qwa_host_model.stop();
      chk(72'(burst_active), 72'(1'b1));
      ectl = 4'h3;
      op(qwa_pkg::QWA_CMD_WR_CTRL, 4'h0, 8'h03, 2'd0, 1'b1);
      eshut = 1'b1;
      op(qwa_pkg::QWA_CMD_SHUTDOWN, 4'h0, 8'h01, 2'd0, 1'b1);
      eshut = 1'b0;
      op(qwa_pkg::QWA_CMD_SHUTDOWN, 4'h0, 8'h00, 2'd0, 1'b1);
      $display("burst and shutdown test done");
      {ewb[1], eaw[1]} = {9'h100, 9'h0ff};
      op(qwa_pkg::QWA_CMD_SCALE, 4'h1, 8'h81, 2'd0, 1'b1);
      op(qwa_pkg::QWA_CMD_SW_RESET, 4'h0, 8'h00, 2'd0, 1'b1);
      for (int i = 0; i < 4; i++) setw(i, (i == 1) ? nvs : 8'h00);
      op(qwa_pkg::QWA_CMD_NOP, 4'h0, 8'h00, 2'd0, 1'b1);
      $display("scale and preset test done");
      repeat (3) @(posedge clk_sys);
      tally_and_finish();
   end
endmodule : qwa_wiper_ctrl_bench
